// [dv/psc_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module psc_cpu_model
  import psc_pkg::*;
(
  input  wire logic      core_clk,
  input  wire psc_rail_t rail,
  output logic           io_rail_good,
  output logic           core_rail_good,
  output logic           sleep_request_pin,
  output logic           push_button_wake,
  output logic           warm_reset_input
);
  logic [2:0] io_dly   = 3'h0;
  logic [2:0] core_dly = 3'h0;

  // ----------------------------------------
  // rail comparators: good a few cycles after enable
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    io_dly   <= rail.main_en ? {io_dly[1:0], 1'b1} : 3'h0;
    core_dly <= rail.core_en ? {core_dly[1:0], 1'b1} : 3'h0;
  end
  assign io_rail_good   = io_dly[2];
  assign core_rail_good = core_dly[2];

  // ----------------------------------------
  // processor pin and buttons
  // ----------------------------------------
  initial begin
    sleep_request_pin = 1'b0;
    push_button_wake  = 1'b0;
    warm_reset_input  = 1'b1;
  end

  // no supply present, no auto wait arm
  task automatic set_sleep(input logic v);
    @(posedge core_clk) sleep_request_pin <= v;
  endtask : set_sleep

  // warm reset pin is active low, button active high
  task automatic press(input logic warm, input int len);
    @(posedge core_clk);
    if (warm) begin
      warm_reset_input <= 1'b0;
    end else begin
      push_button_wake <= 1'b1;
    end
    repeat (len) @(posedge core_clk);
    warm_reset_input <= 1'b1;
    push_button_wake <= 1'b0;
  endtask : press
endmodule : psc_cpu_model
`default_nettype wire

// [dv/psc_power_ctrl_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end
`define WAITC(cnd, lim) \
  for (int w = 0; w < (lim) && !(cnd); w++) @(negedge core_clk);
module psc_power_ctrl_test;
  import psc_pkg::*;
  localparam int HOLD_S = 50;
  localparam int HOLD_L = 100;
  localparam int PULSE  = 8;

  logic           core_clk = 1'b0;
  logic           nrst = 1'b0;
  logic           main_default_select = 1'b0;
  logic           slp_en = 1'b0;
  logic           slp_coff = 1'b0;
  logic           cover_present = 1'b1;
  logic           reset_delay_select = 1'b0;
  logic           sequence_order_pin = 1'b0;
  logic           over_temp = 1'b0;
  logic           button_irq_mask = 1'b0;
  logic           clk_en = 1'b1;
  logic           supply_undervolt = 1'b0;
  logic [3:0]     core_v = 4'hA;
  logic           sleep_pin;
  logic           push_button_wake;
  logic           warm_reset_input;
  logic           io_rail_good;
  logic           core_rail_good;
  psc_sleep_cfg_t sleep_cfg;
  psc_rail_t      rail;
  logic           sleep_active;
  logic           button_irq;
  logic           cover_irq;
  logic           system_reset_out;
  logic           processor_reset_out;
  logic           supply_fail_out;
  int             errors = 0;
  int             compares = 0;

  assign sleep_cfg = {sleep_pin, slp_en, slp_coff, 4'h3, core_v};

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  psc_power_ctrl #(.HOLD_SHORT_CYC(HOLD_S), .HOLD_LONG_CYC(HOLD_L), .CPU_PULSE_CYC(PULSE),
                   .DEB_CYC(4), .RAMP_CYC(4)) psc_power_ctrl_i (
    .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
    .main_default_select(main_default_select), .sleep_cfg(sleep_cfg),
    .push_button_wake(push_button_wake), .warm_reset_input(warm_reset_input),
    .cover_present(cover_present), .reset_delay_select(reset_delay_select),
    .sequence_order_pin(sequence_order_pin), .io_rail_good(io_rail_good),
    .core_rail_good(core_rail_good), .supply_undervolt(supply_undervolt),
    .over_temp(over_temp),
    .button_irq_mask(button_irq_mask), .cover_irq_mask(1'b0), .rail(rail),
    .sleep_active(sleep_active), .button_irq(button_irq), .cover_irq(cover_irq),
    .system_reset_out(system_reset_out), .processor_reset_out(processor_reset_out),
    .supply_fail_out(supply_fail_out));

  psc_cpu_model psc_cpu_model_i (
    .core_clk(core_clk), .rail(rail), .io_rail_good(io_rail_good),
    .core_rail_good(core_rail_good), .sleep_request_pin(sleep_pin),
    .push_button_wake(push_button_wake), .warm_reset_input(warm_reset_input));

  task automatic conclude;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------
  // reset, ramp and hold of system reset
  // ----------------------------------------
  task automatic boot(input logic dsel, input logic lsel, input logic seq,
                      input logic [11:0] mv, input int hold);
    int n;
    @(posedge core_clk) nrst <= 1'b0;
    main_default_select <= dsel;
    reset_delay_select  <= lsel;
    sequence_order_pin  <= seq;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    `CHK(system_reset_out, 1'b0)
    `WAITC(rail.core_en | rail.main_en, 200)
    `CHK({rail.core_en, rail.main_en}, {~seq, seq})
    `WAITC(io_rail_good, 200)
    `CHK(processor_reset_out, 1'b0)
    n = 0;
    while (system_reset_out !== 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    `CHK(n >= hold - 1 && n <= hold + 6, 1'b1)
    `CHK(rail.io_rail_mv, mv)
    `WAITC(supply_fail_out, 20)
    `CHK(supply_fail_out, 1'b1)
  endtask : boot

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    conclude();
  end

  initial begin
    int n;
    boot(1'b0, 1'b0, 1'b0, PSC_IO_MV_LOW, HOLD_S);
    psc_cpu_model_i.set_sleep(1'b1);
    repeat (30) @(negedge core_clk);
    `CHK(sleep_active, 1'b0)
    @(posedge core_clk) slp_en <= 1'b1;
    `WAITC(sleep_active, 30)
    `CHK(sleep_active, 1'b1)
    `CHK(rail.core_target, 4'h3)
    // frozen block ignores the pin drop
    @(posedge core_clk) clk_en <= 1'b0;
    psc_cpu_model_i.set_sleep(1'b0);
    repeat (10) @(negedge core_clk);
    `CHK(sleep_active, 1'b1)
    @(posedge core_clk) clk_en <= 1'b1;
    `WAITC(!sleep_active, 30)
    `CHK(sleep_active, 1'b0)
    psc_cpu_model_i.set_sleep(1'b1);
    `WAITC(sleep_active, 30)
    `CHK(sleep_active, 1'b1)
    // core setting changes during sleep, button exit restores old one
    @(posedge core_clk) core_v <= 4'h5;
    psc_cpu_model_i.press(1'b0, 10);
    `WAITC(!sleep_active, 40)
    `CHK(sleep_active, 1'b0)
    `CHK(rail.core_target, 4'hA)
    `CHK(button_irq, 1'b1)
    repeat (30) @(negedge core_clk);
    `CHK(sleep_active, 1'b0)
    @(posedge core_clk) button_irq_mask <= 1'b1;
    core_v <= 4'hA;
    repeat (2) @(negedge core_clk);
    `CHK(button_irq, 1'b0)
    // new edge by enable bit toggle, core off
    @(posedge core_clk) button_irq_mask <= 1'b0;
    slp_coff <= 1'b1;
    slp_en <= 1'b0;
    @(posedge core_clk) slp_en <= 1'b1;
    `WAITC(sleep_active, 30)
    `CHK({sleep_active, rail.core_en}, 2'b10)
    @(posedge core_clk) slp_en <= 1'b0;
    `WAITC(!sleep_active, 30)
    `CHK(sleep_active, 1'b0)
    @(posedge core_clk) slp_coff <= 1'b0;
    slp_en <= 1'b1;
    `WAITC(sleep_active, 30)
    psc_cpu_model_i.press(1'b1, 2);
    repeat (30) @(negedge core_clk);
    `CHK({sleep_active, processor_reset_out}, 2'b11)
    // pulse starts while the pin is still held, so measure alongside
    fork
      psc_cpu_model_i.press(1'b1, 10);
    join_none
    `WAITC(!processor_reset_out, 40)
    `CHK(processor_reset_out, 1'b0)
    n = 0;
    while (processor_reset_out === 1'b0 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    `CHK(n, PULSE)
    `CHK(sleep_active, 1'b0)
    `CHK(rail.core_target, 4'hA)
    `CHK(button_irq, 1'b1)
    @(posedge core_clk) cover_present <= 1'b0;
    `WAITC(!supply_fail_out, 40)
    `CHK(supply_fail_out, 1'b0)
    // interrupt sets one cycle after the fail output drops
    @(negedge core_clk);
    `CHK(cover_irq, 1'b1)
    `WAITC(!rail.main_en && !rail.core_en, 200)
    `CHK({rail.main_en, rail.core_en, rail.ldo_low_power}, 3'b001)
    `WAITC(!system_reset_out, 20)
    `CHK(system_reset_out, 1'b0)
    @(posedge core_clk) cover_present <= 1'b1;
    boot(1'b1, 1'b1, 1'b1, PSC_IO_MV_HIGH, HOLD_L);
    @(posedge core_clk) over_temp <= 1'b1;
    `WAITC(!supply_fail_out, 40)
    `CHK(supply_fail_out, 1'b0)
    @(posedge core_clk) over_temp <= 1'b0;
    `WAITC(!system_reset_out, 40)
    `CHK(system_reset_out, 1'b0)
    `WAITC(system_reset_out, 300)
    `CHK(supply_fail_out, 1'b1)
    @(posedge core_clk) supply_undervolt <= 1'b1;
    `WAITC(!supply_fail_out, 40)
    `CHK(supply_fail_out, 1'b0)
    conclude();
  end
endmodule : psc_power_ctrl_test
`default_nettype wire

// [rtl/psc_debounce.sv]
`timescale 1ns/1ps
`default_nettype none
module psc_debounce
  import psc_pkg::*;
#(
  parameter int DEB_CYC = PSC_DEB_CYC
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic clk_en,
  input  wire logic raw,
  input  wire logic rst_level,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  localparam int CW = $clog2(DEB_CYC + 1);
  initial begin
    if (DEB_CYC < 1) $error("debounce count must be at least 1");
  end

  typedef struct packed {
    logic [2:0]    sync;
    logic [CW-1:0] cnt;
    logic          level;
    logic          rise;
    logic          fall;
  } psc_deb_t;

  psc_deb_t st;
  psc_deb_t next_st;

  always_comb begin
    next_st      = st;
    next_st.sync = {st.sync[1:0], raw};
    next_st.rise = 1'b0;
    next_st.fall = 1'b0;
    if (st.sync[2] != st.sync[1] || st.sync[2] == st.level) begin
      next_st.cnt = '0;
    end else if (st.cnt == CW'(DEB_CYC - 1)) begin
      next_st.cnt   = '0;
      next_st.level = st.sync[2];
      next_st.rise  = st.sync[2];
      next_st.fall  = ~st.sync[2];
    end else begin
      next_st.cnt = st.cnt + CW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // reset level is a constant per instance, applied combinationally until first accept
  logic seen;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      seen <= 1'b0;
    end else if (clk_en && (next_st.rise || next_st.fall)) begin
      seen <= 1'b1;
    end
  end

  assign level = seen ? st.level : rst_level;
  assign rise  = st.rise && (rst_level == 1'b0 || seen);
  assign fall  = st.fall && seen;

  a_deb_stable: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(st.level) |-> $past(st.sync[2]))
    else $error("debounced level rose without stable input");
endmodule : psc_debounce
`default_nettype wire

// [rtl/psc_power_ctrl.sv]
// Overview of operation
// - default io rail 1.8 or 3.3 V
// - ignore sleep pin without enable bit
// - enter sleep on gated rising edge
// - sleep lowers core or turns it off
// - leave sleep on pin, bit, buttons
// - button exit restores prior core voltage
// - debounce button, interrupt each press
// - warm reset acts like button except core restore, resets cpu
// - warm reset keeps configuration intact
// - debounce warm reset input
// - cover removal interrupts, holds fail low
// - cover removal shuts converters, ldos low
// - debounce cover, high means present
// - system reset follows io power good
// - hold delay 100 ms or 1 s
// - cpu reset pulse, forces sleep exit
// - cpu reset low with system reset
// - sequence pin picks ramp order
// - fail low on uvlo, heat, cover
`timescale 1ns/1ps
`default_nettype none
module psc_power_ctrl
  import psc_pkg::*;
#(
  parameter int HOLD_SHORT_CYC = PSC_HOLD_SHORT_CYC,
  parameter int HOLD_LONG_CYC  = PSC_HOLD_LONG_CYC,
  parameter int CPU_PULSE_CYC  = PSC_CPU_PULSE_CYC,
  parameter int DEB_CYC        = PSC_DEB_CYC,
  parameter int RAMP_CYC       = 64
) (
  input  wire logic           core_clk,
  input  wire logic           nrst,
  input  wire logic           clk_en,
  input  wire logic           main_default_select,
  input  wire psc_sleep_cfg_t sleep_cfg,
  input  wire logic           push_button_wake,
  input  wire logic           warm_reset_input,
  input  wire logic           cover_present,
  input  wire logic           reset_delay_select,
  input  wire logic           sequence_order_pin,
  input  wire logic           io_rail_good,
  input  wire logic           core_rail_good,
  input  wire logic           supply_undervolt,
  input  wire logic           over_temp,
  input  wire logic           button_irq_mask,
  input  wire logic           cover_irq_mask,
  output psc_rail_t           rail,
  output logic                sleep_active,
  output logic                button_irq,
  output logic                cover_irq,
  output logic                system_reset_out,
  output logic                processor_reset_out,
  output logic                supply_fail_out
);
  localparam int PW = $clog2(CPU_PULSE_CYC + 1);
  localparam int RW = $clog2(RAMP_CYC + 1);
  initial begin
    if (CPU_PULSE_CYC < 1 || RAMP_CYC < 1) $error("pulse and ramp counts must be positive");
  end

  //--------------------------------------------------------------
  // pin synchronisers and debouncers
  //--------------------------------------------------------------
  logic [2:0] sleep_sync;
  logic       sleep_pin;
  logic       pb_rise;
  logic       wr_fall;
  logic       wr_level;
  logic       cov_level;
  logic       cov_fall;
  logic       sys_released;

  psc_debounce #(.DEB_CYC(DEB_CYC)) u_pb (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clk_en   (clk_en),
    .raw      (push_button_wake),
    .rst_level(1'b0),
    .level    (),
    .rise     (pb_rise),
    .fall     ()
  );

  psc_debounce #(.DEB_CYC(DEB_CYC)) u_wr (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clk_en   (clk_en),
    .raw      (warm_reset_input),
    .rst_level(1'b1),
    .level    (wr_level),
    .rise     (),
    .fall     (wr_fall)
  );

  psc_debounce #(.DEB_CYC(DEB_CYC)) u_cov (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clk_en   (clk_en),
    .raw      (cover_present),
    .rst_level(1'b0),
    .level    (cov_level),
    .rise     (),
    .fall     (cov_fall)
  );

  psc_reset_timer #(.SHORT_CYC(HOLD_SHORT_CYC), .LONG_CYC(HOLD_LONG_CYC)) u_rt (
    .core_clk(core_clk),
    .nrst    (nrst),
    .clk_en  (clk_en),
    .io_good (io_rail_good && rail.main_en),
    .long_sel(reset_delay_select),
    .released(sys_released)
  );

  //--------------------------------------------------------------
  // power state
  //--------------------------------------------------------------
  typedef enum logic [2:0] {
    PS_OFF,
    PS_RAMP_FIRST,
    PS_RAMP_SECOND,
    PS_ON,
    PS_DOWN_FIRST,
    PS_DOWN_SECOND
  } psc_state_t;

  typedef struct packed {
    psc_state_t              state;
    logic [RW-1:0]           ramp;
    logic                    sleep;
    logic                    gate_prev;
    logic                    pin_hold;
    logic [PSC_CORE_V_W-1:0] saved_core;
    logic                    restore;
    logic [PW-1:0]           pulse;
    logic                    cpu_pulse;
    logic                    pb_irq;
    logic                    cv_irq;
    logic                    io_sel;
    logic                    io_sel_ok;
    logic                    main_en;
    logic                    core_en;
  } psc_ctrl_t;

  psc_ctrl_t st;
  psc_ctrl_t next_st;
  logic      gated;
  logic      sleep_exit;
  logic      fault;

  // pin change counts once second and third stages agree
  assign sleep_pin = (sleep_sync[2] == sleep_sync[1]) ? sleep_sync[2] : st.pin_hold;

  always_comb begin
    gated = sleep_pin & sleep_cfg.sleep_enable_bit;
    fault = supply_undervolt | over_temp | ~cov_level;
    sleep_exit = ~gated | pb_rise | wr_fall | st.cpu_pulse;
    next_st = st;
    next_st.gate_prev = gated;
    next_st.pin_hold  = sleep_pin;
    if (!st.io_sel_ok) begin
      next_st.io_sel    = main_default_select;
      next_st.io_sel_ok = 1'b1;
    end
    if (pb_rise || wr_fall) begin
      next_st.pb_irq = 1'b1;
    end else if (button_irq_mask) begin
      next_st.pb_irq = 1'b0;
    end
    if (cov_fall) begin
      next_st.cv_irq = 1'b1;
    end else if (cover_irq_mask) begin
      next_st.cv_irq = 1'b0;
    end
    // cpu reset pulse when core in regulation
    if (wr_fall && core_rail_good) begin
      next_st.cpu_pulse = 1'b1;
      next_st.pulse     = PW'(CPU_PULSE_CYC - 1);
    end else if (st.cpu_pulse) begin
      if (st.pulse == '0) begin
        next_st.cpu_pulse = 1'b0;
      end else begin
        next_st.pulse = st.pulse - PW'(1);
      end
    end
    // enter on fresh gated edge only
    if (!st.sleep) begin
      if (gated && !st.gate_prev && st.state == PS_ON && !sleep_exit) begin
        next_st.sleep      = 1'b1;
        next_st.saved_core = sleep_cfg.core_volt;
        next_st.restore    = 1'b0;
      end
    end else if (sleep_exit) begin
      next_st.sleep = 1'b0;
      next_st.restore = pb_rise;
    end
    if (gated && !st.gate_prev && !st.sleep) begin
      next_st.restore = 1'b0;
    end
    case (st.state)
      PS_OFF: begin
        next_st.ramp = '0;
        if (!fault) begin
          next_st.state = PS_RAMP_FIRST;
          if (sequence_order_pin) begin
            next_st.main_en = 1'b1;
          end else begin
            next_st.core_en = 1'b1;
          end
        end
      end
      PS_RAMP_FIRST, PS_DOWN_FIRST: begin
        if (st.ramp == RW'(RAMP_CYC - 1)) begin
          next_st.ramp  = '0;
          next_st.state = (st.state == PS_RAMP_FIRST) ? PS_RAMP_SECOND : PS_DOWN_SECOND;
          if (st.state == PS_RAMP_FIRST) begin
            next_st.main_en = 1'b1;
            next_st.core_en = 1'b1;
          end else begin
            next_st.main_en = 1'b0;
            next_st.core_en = 1'b0;
          end
        end else begin
          next_st.ramp = st.ramp + RW'(1);
        end
      end
      PS_RAMP_SECOND: begin
        next_st.state = PS_ON;
      end
      PS_ON: begin
        if (fault) begin
          next_st.state = PS_DOWN_FIRST;
          next_st.sleep = 1'b0;
          next_st.ramp  = '0;
          // the one that came up first goes down last
          if (sequence_order_pin) begin
            next_st.core_en = 1'b0;
          end else begin
            next_st.main_en = 1'b0;
          end
        end
      end
      PS_DOWN_SECOND: begin
        next_st.state = PS_OFF;
      end
      default: begin
        next_st.state = PS_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st         <= '0;
      st.state   <= PS_OFF;
      sleep_sync <= 3'h0;
    end else if (clk_en) begin
      st         <= next_st;
      sleep_sync <= {sleep_sync[1:0], sleep_cfg.sleep_request_pin};
    end
  end

  //--------------------------------------------------------------
  // outputs
  //--------------------------------------------------------------
  always_comb begin
    rail.io_rail_mv    = st.io_sel ? PSC_IO_MV_HIGH : PSC_IO_MV_LOW;
    rail.main_en       = st.main_en;
    // core off or low voltage in sleep
    rail.core_en       = st.core_en & ~(st.sleep & sleep_cfg.core_off_in_sleep);
    rail.core_target   = st.sleep ? sleep_cfg.core_lp_volt :
                         (st.restore ? st.saved_core : sleep_cfg.core_volt);
    rail.ldo_low_power = st.sleep | ~cov_level;
  end

  assign sleep_active        = st.sleep;
  assign button_irq          = st.pb_irq & sys_released;
  assign cover_irq           = st.cv_irq & sys_released;
  assign system_reset_out    = sys_released;
  assign processor_reset_out = sys_released & ~st.cpu_pulse;
  assign supply_fail_out     = sys_released & ~fault;

  a_sleep_gate: assert property (@(posedge core_clk) disable iff (!nrst)
    !sleep_cfg.sleep_enable_bit && clk_en |=> !st.sleep)
    else $error("sleep entered without enable bit");
  a_sleep_edge: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(st.sleep) |-> $past(gated) && !$past(st.gate_prev))
    else $error("sleep entered without gated rising edge");
  a_core_lp: assert property (@(posedge core_clk) disable iff (!nrst)
    st.sleep && sleep_cfg.core_off_in_sleep |-> !rail.core_en)
    else $error("core rail on in sleep with core off set");
  a_sleep_exit: assert property (@(posedge core_clk) disable iff (!nrst)
    st.sleep && clk_en && pb_rise |=> !st.sleep)
    else $error("sleep not left on button");
  a_restore_core: assert property (@(posedge core_clk) disable iff (!nrst)
    st.sleep && pb_rise && clk_en |=> rail.core_target == $past(st.saved_core))
    else $error("core voltage not restored after button exit");
  a_cpu_pulse: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && wr_fall && core_rail_good ##1 clk_en |-> !processor_reset_out)
    else $error("cpu reset not asserted on warm reset");
  a_cpu_follow: assert property (@(posedge core_clk) disable iff (!nrst)
    !system_reset_out |-> !processor_reset_out)
    else $error("cpu reset released while system reset low");
  a_fail_cover: assert property (@(posedge core_clk) disable iff (!nrst)
    !cov_level |-> !supply_fail_out && rail.ldo_low_power)
    else $error("supply fail high with cover removed");
  a_cover_down: assert property (@(posedge core_clk) disable iff (!nrst)
    st.state == PS_ON && !cov_level && clk_en |=> st.state == PS_DOWN_FIRST)
    else $error("converters not shut down on cover removal");
endmodule : psc_power_ctrl
`default_nettype wire

// [rtl/psc_reset_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module psc_reset_timer
  import psc_pkg::*;
#(
  parameter int SHORT_CYC = PSC_HOLD_SHORT_CYC,
  parameter int LONG_CYC  = PSC_HOLD_LONG_CYC
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic clk_en,
  input  wire logic io_good,
  input  wire logic long_sel,
  output logic      released
);
  initial begin
    if (SHORT_CYC < 1 || LONG_CYC < 1) $error("hold counts must be positive");
  end

  typedef struct packed {
    logic [31:0] cnt;
    logic        released;
  } psc_rt_t;

  psc_rt_t st;
  psc_rt_t next_st;

  always_comb begin
    next_st = st;
    // low while io rail not good
    if (!io_good) begin
      next_st.cnt      = '0;
      next_st.released = 1'b0;
    end else if (!st.released) begin
      if (st.cnt >= 32'(long_sel ? LONG_CYC - 1 : SHORT_CYC - 1)) begin
        next_st.released = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign released = st.released;

  a_rt_good_low: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && !io_good |=> !released)
    else $error("system reset released while io rail not good");
endmodule : psc_reset_timer
`default_nettype wire

// [shared/psc_pkg.sv]
package psc_pkg;
  // io rail default target in millivolts
  localparam logic [11:0] PSC_IO_MV_LOW   = 12'h708;
  localparam logic [11:0] PSC_IO_MV_HIGH  = 12'hCE4;
  // timing
  localparam int          PSC_CLK_MHZ     = 125;
  localparam int          PSC_HOLD_SHORT_MS = 100;
  localparam int          PSC_HOLD_LONG_MS  = 1000;
  localparam int          PSC_HOLD_SHORT_CYC = PSC_HOLD_SHORT_MS * PSC_CLK_MHZ * 1000;
  localparam int          PSC_HOLD_LONG_CYC  = PSC_HOLD_LONG_MS * PSC_CLK_MHZ * 1000;
  localparam int          PSC_CPU_PULSE_US   = 100;
  localparam int          PSC_CPU_PULSE_CYC  = PSC_CPU_PULSE_US * PSC_CLK_MHZ;
  localparam int          PSC_DEB_CYC        = 16;
  // core converter configuration field layout
  localparam int          PSC_CORE_V_W    = 4;

  typedef struct packed {
    logic sleep_request_pin;
    logic sleep_enable_bit;
    logic core_off_in_sleep;
    logic [PSC_CORE_V_W-1:0] core_lp_volt;
    logic [PSC_CORE_V_W-1:0] core_volt;
  } psc_sleep_cfg_t;

  typedef struct packed {
    logic       core_en;
    logic       main_en;
    logic       ldo_low_power;
    logic [PSC_CORE_V_W-1:0] core_target;
    logic [11:0] io_rail_mv;
  } psc_rail_t;
endpackage : psc_pkg
